// [rtl/sfmc_pkg.sv]
// Constants, opcodes and carrier types for the serial flash mode-control core.
// Assumes one system clock that is much faster than the serial clock pin.
package sfmc_pkg;

  // ---------------------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_WR_SR      = 8'h01;
  localparam logic [7:0] OP_RD_SR1     = 8'h05;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_RD_BANK    = 8'h16;
  localparam logic [7:0] OP_WR_BANK    = 8'h17;
  localparam logic [7:0] OP_RD_SR2     = 8'h35;
  localparam logic [7:0] OP_QCMD_ENTER = 8'h38;
  localparam logic [7:0] OP_VOL_WR_EN  = 8'h50;
  localparam logic [7:0] OP_RD_PARAM   = 8'h5a;
  localparam logic [7:0] OP_RST_EN     = 8'h66;
  localparam logic [7:0] OP_RST        = 8'h99;
  localparam logic [7:0] OP_ADDR4_ON   = 8'hb7;
  localparam logic [7:0] OP_ADDR4_OFF  = 8'he9;
  localparam logic [7:0] OP_QREAD      = 8'heb;
  localparam logic [7:0] OP_QREAD4     = 8'hec;
  localparam logic [7:0] OP_QCMD_EXIT  = 8'hf5;

  // ---------------------------------------------------------------------------
  // Register fields and reset values
  // ---------------------------------------------------------------------------
  localparam int         SR1_BUSY_BIT  = 0;
  localparam int         SR1_WEL_BIT   = 1;
  localparam int         SR2_QE_BIT    = 1;
  localparam int         BANK_4B_BIT   = 7;
  localparam logic [7:0] SR1_WR_MASK   = 8'hfc;
  localparam logic [7:0] SR2_WR_MASK   = 8'hff;
  localparam logic [7:0] SR1_RST       = 8'h00;
  localparam logic [7:0] SR2_RST       = 8'h00;
  localparam logic [7:0] BANK_RST      = 8'h00;

  // ---------------------------------------------------------------------------
  // Continuous read mode bits and forced exit
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MODE_ENTER    = 8'ha5;
  localparam logic [3:0] MODE_ENTER_HI = 4'ha;
  localparam logic [7:0] MODE_EXIT     = 8'h00;
  localparam logic [3:0] EXIT_NIBBLE   = 4'hf;
  localparam logic [3:0] EXIT_CLOCKS   = 4'h8;

  // ---------------------------------------------------------------------------
  // Phase lengths in bits
  // ---------------------------------------------------------------------------
  localparam logic [5:0] CMD_BITS      = 6'h08;
  localparam logic [5:0] ADDR3_BITS    = 6'h18;
  localparam logic [5:0] ADDR4_BITS    = 6'h20;
  localparam logic [5:0] MODE_BITS     = 6'h08;
  localparam logic [5:0] QDUMMY_BITS   = 6'h10;
  localparam logic [5:0] PDUMMY_BITS   = 6'h08;

  // ---------------------------------------------------------------------------
  // Parameter table contents, pin vector width and pin reset levels
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PARAM_DW15      = 32'hff5df622;
  localparam logic [31:0] PARAM_DW16      = 32'ha1f860e8;
  localparam logic [5:0]  PARAM_DW15_ADDR = 6'h0e;
  localparam logic [5:0]  PARAM_DW16_ADDR = 6'h0f;

  localparam int         PIN_W         = 7;
  localparam logic [6:0] PIN_RST       = 7'h60;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [5:0] {
    PH_CMD   = 6'h01,
    PH_ADDR  = 6'h02,
    PH_MODE  = 6'h04,
    PH_DUMMY = 6'h08,
    PH_DIN   = 6'h10,
    PH_OUT   = 6'h20
  } sfmc_phase_t;

  typedef struct packed {
    logic       hw_rst_n;
    logic       cs_n;
    logic       sclk;
    logic [3:0] dq;
  } sfmc_pins_t;

  typedef struct packed {
    logic four_line_command_mode;
    logic cont_read;
    logic four_byte_addr;
    logic quad_lane_enable_bit;
  } sfmc_modes_t;

  typedef struct packed {
    sfmc_phase_t phase;
    logic        sclk_prev;
    logic        cs_prev;
    logic        rst_prev;
    logic [7:0]  opcode;
    logic [31:0] shift;
    logic [5:0]  cnt;
    logic [31:0] addr;
    logic [7:0]  mode_byte;
    logic        mode_seen;
    logic [1:0]  nbytes;
    logic [7:0]  din0;
    logic [7:0]  din1;
    logic [7:0]  cur;
    logic [2:0]  opos;
    logic [3:0]  dq_o;
    logic [3:0]  dq_oe;
    logic [31:0] arr_addr;
    logic        arr_rd;
    logic [3:0]  clk_cnt;
    logic        all_f;
    logic        quad_cmd;
    logic        cont;
    logic [7:0]  bank;
    logic        wel;
    logic        vwe;
    logic        rst_arm;
    logic [7:0]  nv_sr1;
    logic [7:0]  v_sr1;
    logic [7:0]  nv_sr2;
    logic [7:0]  v_sr2;
  } sfmc_state_t;

endpackage

// [rtl/sfmc_sync.sv]
// Two-stage synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; no bus coherence is promised.
module sfmc_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfmc_sync_st_t;

  sfmc_sync_st_t st_q;
  sfmc_sync_st_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q <= '{s1: RST, s2: RST};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// [rtl/sfmc_core.sv]
// Serial flash command decoder for interface width, addressing and status modes.
// Assumes sclk runs below a quarter of sys_clk; array data comes from an outside
// engine one cycle after arr_rd, and op_busy comes from logic on sys_clk.

// Contract
// - Parameter table reports hold/protect disable absent
// - Quad enable is status-2 bit 1
// - 05h returns status 1, 35h status 2
// - Two-byte 01h sets or clears quad enable
// - Mode byte A5h or Ax enters continuous
// - Mode byte 00h leaves continuous after read
// - Eight clocks of Fh force continuous exit
// - 38h enters four-line command mode
// - Four-line F5h returns to single-line
// - B7h enters 4-byte addressing, no enable
// - Bank bit 7 set selects 4-byte addressing
// - Bank bit 7 clear: bank picks segment
// - 16h reads bank, 17h writes one byte
// - E9h leaves 4-byte addressing, no enable
// - Any reset returns 3-byte addressing
// - Reset only when 66h directly precedes 99h
// - Reset pair accepted at current width
// - Status 1 restores non-volatile; 06h gates it
// - 50h enables and activates volatile status
// - Dedicated 4-byte read carries full address; continuous frames after ECh run as EBh, 3-byte unless bank bit 7 set
// - Parameter dword fifteen reads FF5DF622
// - Status 1 bit 0 shows busy
module sfmc_core (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 pin_sclk,
  input  wire logic                 pin_cs_n,
  input  wire logic                 pin_hw_rst_n,
  input  wire logic [3:0]           quad_data_lines_i,
  output logic      [3:0]           quad_data_lines_o,
  output logic      [3:0]           quad_data_lines_oe,
  input  wire logic                 op_busy,
  input  wire logic [7:0]           arr_rdata,
  output logic      [31:0]          arr_addr,
  output logic                      arr_rd,
  output sfmc_pkg::sfmc_modes_t     modes,
  output logic      [7:0]           address_bank_register
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  sfmc_pkg::sfmc_pins_t pins_s;

  sfmc_sync #(
    .W   (sfmc_pkg::PIN_W),
    .RST (sfmc_pkg::PIN_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       ({pin_hw_rst_n, pin_cs_n, pin_sclk, quad_data_lines_i}),
    .q       (pins_s)
  );

  sfmc_pkg::sfmc_state_t st_q;
  sfmc_pkg::sfmc_state_t st_d;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] param_byte(input logic [7:0] a);
    logic [31:0] dw;
    dw = 32'hffffffff;
    if (a[7:2] == sfmc_pkg::PARAM_DW15_ADDR)
    begin
      dw = sfmc_pkg::PARAM_DW15;
    end
    else if (a[7:2] == sfmc_pkg::PARAM_DW16_ADDR)
    begin
      dw = sfmc_pkg::PARAM_DW16;
    end
    return dw[{a[1:0], 3'b000} +: 8];
  endfunction

  function automatic logic is_qread(input logic [7:0] op);
    return (op == sfmc_pkg::OP_QREAD) || (op == sfmc_pkg::OP_QREAD4);
  endfunction

  logic       rise;
  logic       fall;
  logic       frame_end;
  logic       quad_lanes;
  logic [5:0] step;
  logic [7:0] sr1_view;
  logic [5:0] addr_bits;

  // Status 1 shows the volatile copy in bits 7:2, which mirrors the stored one
  // unless 50h writes diverged it; bits 1 and 0 show WEL and op_busy
  assign sr1_view = {st_q.v_sr1[7:2], st_q.wel, op_busy};
  assign rise      = pins_s.sclk & ~st_q.sclk_prev & ~pins_s.cs_n;
  assign fall      = ~pins_s.sclk & st_q.sclk_prev & ~pins_s.cs_n;
  assign frame_end = pins_s.cs_n & ~st_q.cs_prev;
  // Opcode width follows the current mode, so the reset pair works either way
  assign quad_lanes = st_q.quad_cmd
                    | (is_qread(st_q.opcode) & (st_q.phase != sfmc_pkg::PH_CMD));
  assign step = quad_lanes ? 6'h04 : 6'h01;
  assign addr_bits = ((st_q.opcode == sfmc_pkg::OP_QREAD4) || st_q.bank[sfmc_pkg::BANK_4B_BIT])
                   ? sfmc_pkg::ADDR4_BITS : sfmc_pkg::ADDR3_BITS;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] sh;
    logic [5:0]  c;
    logic [7:0]  b;
    logic        soft_rst;
    sh       = '0;
    c        = '0;
    b        = '0;
    soft_rst = 1'b0;
    st_d           = st_q;
    st_d.sclk_prev = pins_s.sclk;
    st_d.cs_prev   = pins_s.cs_n;
    st_d.rst_prev  = pins_s.hw_rst_n;
    st_d.arr_rd    = 1'b0;

    if (pins_s.cs_n)
    begin
      // Idle frame: continuous mode resumes straight at the address
      st_d.phase     = st_q.cont ? sfmc_pkg::PH_ADDR : sfmc_pkg::PH_CMD;
      st_d.opcode    = st_q.cont ? sfmc_pkg::OP_QREAD : 8'h00;
      st_d.cnt       = '0;
      st_d.nbytes    = '0;
      st_d.opos      = '0;
      st_d.dq_oe     = '0;
      st_d.clk_cnt   = '0;
      st_d.all_f     = 1'b1;
      st_d.mode_seen = 1'b0;
    end

    // ------------------------------- input on rising sclk
    if (rise)
    begin
      sh = quad_lanes ? {st_q.shift[27:0], pins_s.dq} : {st_q.shift[30:0], pins_s.dq[0]};
      c  = st_q.cnt + step;
      st_d.shift = sh;
      st_d.cnt   = c;
      if (st_q.clk_cnt != sfmc_pkg::EXIT_CLOCKS)
      begin
        st_d.clk_cnt = st_q.clk_cnt + 4'h1;
        if (pins_s.dq != sfmc_pkg::EXIT_NIBBLE)
        begin
          st_d.all_f = 1'b0;
        end
      end
      case (st_q.phase)
        sfmc_pkg::PH_CMD:
        begin
          if (c == sfmc_pkg::CMD_BITS)
          begin
            st_d.opcode = sh[7:0];
            st_d.cnt    = '0;
            case (sh[7:0])
              sfmc_pkg::OP_RD_SR1, sfmc_pkg::OP_RD_SR2, sfmc_pkg::OP_RD_BANK:
                st_d.phase = sfmc_pkg::PH_OUT;
              sfmc_pkg::OP_RD_PARAM, sfmc_pkg::OP_QREAD, sfmc_pkg::OP_QREAD4:
                st_d.phase = sfmc_pkg::PH_ADDR;
              default:
                st_d.phase = sfmc_pkg::PH_DIN;
            endcase
          end
        end
        sfmc_pkg::PH_ADDR:
        begin
          if ((st_q.opcode == sfmc_pkg::OP_RD_PARAM) ? (c == sfmc_pkg::ADDR3_BITS) : (c == addr_bits))
          begin
            st_d.cnt = '0;
            if (c == sfmc_pkg::ADDR4_BITS)
            begin
              st_d.addr = sh;
            end
            else
            begin
              st_d.addr = {1'b0, st_q.bank[6:0], sh[23:0]};
            end
            st_d.phase = is_qread(st_q.opcode) ? sfmc_pkg::PH_MODE : sfmc_pkg::PH_DUMMY;
          end
        end
        sfmc_pkg::PH_MODE:
        begin
          if (c == sfmc_pkg::MODE_BITS)
          begin
            st_d.cnt       = '0;
            st_d.mode_byte = sh[7:0];
            st_d.mode_seen = 1'b1;
            st_d.phase     = sfmc_pkg::PH_DUMMY;
          end
        end
        sfmc_pkg::PH_DUMMY:
        begin
          if (c == (is_qread(st_q.opcode) ? sfmc_pkg::QDUMMY_BITS : sfmc_pkg::PDUMMY_BITS))
          begin
            st_d.cnt      = '0;
            st_d.phase    = sfmc_pkg::PH_OUT;
            st_d.arr_addr = st_q.addr;
            st_d.arr_rd   = is_qread(st_q.opcode);
          end
        end
        sfmc_pkg::PH_DIN:
        begin
          if (c == sfmc_pkg::CMD_BITS)
          begin
            st_d.cnt = '0;
            if (st_q.nbytes == 2'd0)
            begin
              st_d.din0 = sh[7:0];
            end
            else if (st_q.nbytes == 2'd1)
            begin
              st_d.din1 = sh[7:0];
            end
            if (st_q.nbytes != 2'd3)
            begin
              st_d.nbytes = st_q.nbytes + 2'd1;
            end
          end
        end
        sfmc_pkg::PH_OUT:
        begin
          st_d.cnt = '0;
        end
        default:
          st_d.phase = sfmc_pkg::PH_CMD;
      endcase
    end

    // ------------------------------- output on falling sclk
    if (fall && (st_q.phase == sfmc_pkg::PH_OUT))
    begin
      b = st_q.cur;
      if (st_q.opos == 3'd0)
      begin
        case (st_q.opcode)
          sfmc_pkg::OP_RD_SR1:  b = sr1_view;
          sfmc_pkg::OP_RD_SR2:  b = st_q.v_sr2;
          sfmc_pkg::OP_RD_BANK: b = st_q.bank;
          sfmc_pkg::OP_RD_PARAM:
          begin
            b         = param_byte(st_q.addr[7:0]);
            st_d.addr = st_q.addr + 32'h1;
          end
          default:
          begin
            // Prefetch: the next byte is requested as soon as this one is taken
            b             = arr_rdata;
            st_d.arr_addr = st_q.arr_addr + 32'h1;
            st_d.arr_rd   = 1'b1;
          end
        endcase
      end
      st_d.cur = b;
      if (quad_lanes)
      begin
        st_d.dq_o  = (st_q.opos == 3'd0) ? b[7:4] : b[3:0];
        st_d.dq_oe = 4'hf;
      end
      else
      begin
        st_d.dq_o  = {2'b00, b[3'd7 - st_q.opos], 1'b0};
        st_d.dq_oe = 4'h2;
      end
      st_d.opos = st_q.opos + step[2:0];
    end

    // ------------------------------- command completion at chip deselect
    if (frame_end && (st_q.phase != sfmc_pkg::PH_CMD))
    begin
      st_d.rst_arm = (st_q.opcode == sfmc_pkg::OP_RST_EN) && (st_q.nbytes == 2'd0);
      case (st_q.opcode)
        sfmc_pkg::OP_WR_EN:
          st_d.wel = 1'b1;
        sfmc_pkg::OP_VOL_WR_EN:
          st_d.vwe = 1'b1;
        sfmc_pkg::OP_WR_SR:
        begin
          if ((st_q.wel || st_q.vwe) && !op_busy && (st_q.nbytes != 2'd0))
          begin
            st_d.v_sr1 = (st_q.v_sr1 & ~sfmc_pkg::SR1_WR_MASK) | (st_q.din0 & sfmc_pkg::SR1_WR_MASK);
            if (st_q.nbytes != 2'd1)
            begin
              // Second byte carries the quad enable in bit 1
              st_d.v_sr2 = st_q.din1 & sfmc_pkg::SR2_WR_MASK;
            end
            if (st_q.wel && !st_q.vwe)
            begin
              st_d.nv_sr1 = (st_q.nv_sr1 & ~sfmc_pkg::SR1_WR_MASK)
                          | (st_q.din0 & sfmc_pkg::SR1_WR_MASK);
              if (st_q.nbytes != 2'd1)
              begin
                st_d.nv_sr2 = st_q.din1 & sfmc_pkg::SR2_WR_MASK;
              end
            end
          end
          st_d.wel = 1'b0;
          st_d.vwe = 1'b0;
        end
        sfmc_pkg::OP_WR_BANK:
        begin
          if (st_q.nbytes == 2'd1)
          begin
            st_d.bank = st_q.din0;
          end
        end
        sfmc_pkg::OP_ADDR4_ON:
          st_d.bank[sfmc_pkg::BANK_4B_BIT] = 1'b1;
        sfmc_pkg::OP_ADDR4_OFF:
          st_d.bank[sfmc_pkg::BANK_4B_BIT] = 1'b0;
        sfmc_pkg::OP_QCMD_ENTER:
          st_d.quad_cmd = 1'b1;
        sfmc_pkg::OP_QCMD_EXIT:
        begin
          if (st_q.quad_cmd)
          begin
            st_d.quad_cmd = 1'b0;
          end
        end
        sfmc_pkg::OP_RST:
          soft_rst = st_q.rst_arm && (st_q.nbytes == 2'd0);
        sfmc_pkg::OP_QREAD, sfmc_pkg::OP_QREAD4:
        begin
          if (st_q.cont && (st_q.clk_cnt == sfmc_pkg::EXIT_CLOCKS) && st_q.all_f)
          begin
            st_d.cont = 1'b0;
          end
          else if (st_q.mode_seen)
          begin
            // Without quad enable the mode byte is never honoured
            st_d.cont = st_q.v_sr2[sfmc_pkg::SR2_QE_BIT]
                      && ((st_q.mode_byte == sfmc_pkg::MODE_ENTER)
                      || (st_q.mode_byte[7:4] == sfmc_pkg::MODE_ENTER_HI));
            if (st_q.mode_byte == sfmc_pkg::MODE_EXIT)
            begin
              st_d.cont = 1'b0;
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Hardware reset pin acts once on its falling edge, like the software reset
    if (!pins_s.hw_rst_n && st_q.rst_prev)
    begin
      soft_rst = 1'b1;
    end

    if (soft_rst)
    begin
      st_d.bank     = sfmc_pkg::BANK_RST;
      st_d.quad_cmd = 1'b0;
      st_d.cont     = 1'b0;
      st_d.phase    = sfmc_pkg::PH_CMD;
      st_d.opcode   = 8'h00;
      st_d.dq_oe    = '0;
      st_d.wel      = 1'b0;
      st_d.vwe      = 1'b0;
      st_d.rst_arm  = 1'b0;
      st_d.v_sr1    = st_q.nv_sr1;
      st_d.v_sr2    = st_q.nv_sr2;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_q           <= '0;
      st_q.phase     <= sfmc_pkg::PH_CMD;
      st_q.cs_prev   <= 1'b1;
      st_q.rst_prev  <= 1'b1;
      st_q.all_f     <= 1'b1;
      st_q.bank      <= sfmc_pkg::BANK_RST;
      st_q.nv_sr1    <= sfmc_pkg::SR1_RST;
      st_q.v_sr1     <= sfmc_pkg::SR1_RST;
      st_q.nv_sr2    <= sfmc_pkg::SR2_RST;
      st_q.v_sr2     <= sfmc_pkg::SR2_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign quad_data_lines_o            = st_q.dq_o;
  assign quad_data_lines_oe           = st_q.dq_oe;
  assign arr_addr                     = st_q.arr_addr;
  assign arr_rd                       = st_q.arr_rd;
  assign address_bank_register        = st_q.bank;
  assign modes.four_line_command_mode = st_q.quad_cmd;
  assign modes.cont_read              = st_q.cont;
  assign modes.four_byte_addr         = st_q.bank[sfmc_pkg::BANK_4B_BIT];
  assign modes.quad_lane_enable_bit   = st_q.v_sr2[sfmc_pkg::SR2_QE_BIT];

endmodule

// [verification/sfmc_core_asserts.sv]
// Port checker for the mode-control core.
// Assumes srst clears the modes and the bank register and the host holds pin_hw_rst_n low for 8 cycles.
module sfmc_core_asserts (
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic                  pin_cs_n,
  input wire logic                  pin_hw_rst_n,
  input wire logic [3:0]            quad_data_lines_oe,
  input wire logic                  arr_rd,
  input wire sfmc_pkg::sfmc_modes_t modes,
  input wire logic [7:0]            address_bank_register
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_srst_clear;
    disable iff (1'b0) srst |=> modes == '0 && address_bank_register == 8'h00;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("state kept through srst");
  property p_4b_bank;
    modes.four_byte_addr == address_bank_register[7];
  endproperty
  a_4b_bank: assert property (p_4b_bank) else $error("4-byte mode differs from bank bit 7");
  property p_bank_frame_end;
    $changed(address_bank_register) |-> pin_cs_n || !pin_hw_rst_n;
  endproperty
  a_bank_frame_end: assert property (p_bank_frame_end) else $error("bank changed mid-frame");
  property p_qcmd_frame_end;
    $changed(modes.four_line_command_mode) |-> pin_cs_n || !pin_hw_rst_n;
  endproperty
  a_qcmd_frame_end: assert property (p_qcmd_frame_end) else $error("four-line mode changed mid-frame");
  property p_cont_enter;
    $rose(modes.cont_read) |-> pin_cs_n && modes.quad_lane_enable_bit;
  endproperty
  a_cont_enter: assert property (p_cont_enter) else $error("continuous entered wrongly");
  property p_oe_drop;
    $rose(pin_cs_n) |-> ##6 quad_data_lines_oe == 4'h0;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("output enable kept after deselect");
  property p_oe_legal;
    quad_data_lines_oe inside {4'h0, 4'h2, 4'hf};
  endproperty
  a_oe_legal: assert property (p_oe_legal) else $error("illegal output enable pattern");
  property p_arr_pulse;
    arr_rd |=> !arr_rd;
  endproperty
  a_arr_pulse: assert property (p_arr_pulse) else $error("array request too long");
  property p_hw_reset;
    $fell(pin_hw_rst_n) |-> ##8 modes.four_byte_addr == 1'b0 && modes.cont_read == 1'b0
      && modes.four_line_command_mode == 1'b0;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("modes kept after pin reset");

  c_cont: cover property ($rose(modes.cont_read));
  c_qcmd: cover property ($rose(modes.four_line_command_mode));
  c_4b: cover property ($rose(address_bank_register[7]));
endmodule

bind sfmc_core sfmc_core_asserts u_chk (
  .sys_clk              (sys_clk),
  .srst                 (srst),
  .pin_cs_n             (pin_cs_n),
  .pin_hw_rst_n         (pin_hw_rst_n),
  .quad_data_lines_oe   (quad_data_lines_oe),
  .arr_rd               (arr_rd),
  .modes                (modes),
  .address_bank_register(address_bank_register)
);

// [verification/sfmc_host.sv]
// Behavioural serial host for the core's pins.
// Assumes sys_clk at 250 MHz; each sclk level lasts 4 cycles, slow enough for the synchronisers.
module sfmc_host (
  input  wire logic       sys_clk,
  input  wire logic [3:0] dq_i,
  output logic            sclk,
  output logic            cs_n,
  output logic            hw_rst_n,
  output logic [3:0]      dq
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    hw_rst_n = 1'b1;
    dq = 4'h0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Sample on the rising edge, change on the falling one (mode 0)
  task automatic clk1(input logic [3:0] v, output logic [3:0] s);
    dq <= v;
    cyc(4);
    sclk <= 1'b1;
    s = dq_i;
    cyc(4);
    sclk <= 1'b0;
  endtask

  // Bytes go msb first; quad sends the high nibble first
  task automatic byte_x(input logic [7:0] b, input logic q, output logic [7:0] r);
    logic [3:0] s;
    if (q)
    begin
      clk1(b[7:4], s);
      r[7:4] = s;
      clk1(b[3:0], s);
      r[3:0] = s;
    end
    else
      for (int i = 7; i >= 0; i--)
      begin
        clk1({3'b000, b[i]}, s);
        r[i] = s[1];
      end
  endtask

  task automatic sel();
    cs_n <= 1'b0;
    cyc(4);
  endtask

  // Commands act at deselect, so leave room before the next frame
  task automatic desel();
    cyc(4);
    cs_n <= 1'b1;
    cyc(10);
  endtask

  task automatic hw_reset();
    hw_rst_n <= 1'b0;
    cyc(8);
    hw_rst_n <= 1'b1;
    cyc(8);
  endtask
endmodule

// [verification/sfmc_core_tb.sv]
// Self-checking bench for the mode-control core, driven frame by frame.
// Assumes the host model keeps serial timing; array data follows arr_addr.
module sfmc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  sys_clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  op_busy = 1'b0;
  logic [7:0]            arr_rdata = 8'h00;
  logic                  sclk;
  logic                  cs_n;
  logic                  hw_rst_n;
  logic [3:0]            hdq;
  logic [3:0]            dq_o;
  logic [3:0]            oe;
  logic [3:0]            dq_i;
  logic [31:0]           arr_addr;
  logic                  arr_rd;
  sfmc_pkg::sfmc_modes_t modes;
  logic [7:0]            bank;
  logic                  q = 1'b0;
  logic [7:0]            r;
  logic [31:0]           v;
  int                    n_mismatch = 0;
  int                    num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  assign dq_i = (oe & dq_o) | (~oe & hdq);
  always @(posedge sys_clk) arr_rdata <= arr_addr[7:0] ^ 8'h3c;

  sfmc_core dut (.sys_clk(sys_clk), .srst(srst), .pin_sclk(sclk), .pin_cs_n(cs_n),
    .pin_hw_rst_n(hw_rst_n), .quad_data_lines_i(dq_i), .quad_data_lines_o(dq_o),
    .quad_data_lines_oe(oe), .op_busy(op_busy), .arr_rdata(arr_rdata), .arr_addr(arr_addr),
    .arr_rd(arr_rd), .modes(modes), .address_bank_register(bank));
  sfmc_host host (.sys_clk(sys_clk), .dq_i(dq_i), .sclk(sclk), .cs_n(cs_n),
    .hw_rst_n(hw_rst_n), .dq(hdq));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Opcode, then n bytes of d from the top; bytes read back collect in v
  task automatic cmd(input logic [7:0] op, input logic [63:0] d, input int n);
    host.sel();
    host.byte_x(op, q, r);
    for (int i = n - 1; i >= 0; i--)
    begin
      host.byte_x(d[8*i +: 8], q, r);
      v = {r, v[31:8]};
    end
    host.desel();
  endtask

  // In continuous mode the opcode is left out
  task automatic qrd(input logic op, input logic [7:0] m);
    host.sel();
    if (op)
      host.byte_x(8'heb, q, r);
    repeat (3) host.byte_x(8'h00, 1'b1, r);
    host.byte_x(m, 1'b1, r);
    repeat (2) host.byte_x(8'h5a, 1'b1, r);
    host.desel();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("modes", modes, 4'h0);
    chk("bank", bank, 8'h00);
    cmd(8'hb7, 0, 0);
    chk("4b on", modes.four_byte_addr, 1'b1);
    cmd(8'h16, 0, 1);
    chk("bank rd", r, 8'h80);
    cmd(8'he9, 0, 0);
    chk("4b off", modes.four_byte_addr, 1'b0);
    cmd(8'h17, 64'h05, 1);
    chk("bank wr", bank, 8'h05);
    cmd(8'h17, 64'h0706, 2);
    chk("bank 2 bytes", bank, 8'h05);
    cmd(8'h17, 64'h85, 1);
    chk("bank 4b", modes.four_byte_addr, 1'b1);
    cmd(8'h99, 0, 0);
    chk("lone reset", bank, 8'h85);
    cmd(8'h66, 0, 0);
    cmd(8'h05, 0, 1);
    cmd(8'h99, 0, 0);
    chk("split reset", bank, 8'h85);
    cmd(8'h66, 0, 0);
    cmd(8'h99, 0, 0);
    chk("soft reset", bank, 8'h00);
    $display("test addressing done");
    cmd(8'h01, 64'h0002, 2);
    chk("wr no enable", modes.quad_lane_enable_bit, 1'b0);
    cmd(8'h06, 0, 0);
    cmd(8'h01, 64'h0000, 2);
    chk("qe clear", modes.quad_lane_enable_bit, 1'b0);
    cmd(8'h06, 0, 0);
    cmd(8'h01, 64'h0002, 2);
    chk("qe set", modes.quad_lane_enable_bit, 1'b1);
    cmd(8'h35, 0, 1);
    chk("sr2 rd", r, 8'h02);
    op_busy <= 1'b1;
    cmd(8'h05, 0, 1);
    chk("busy", r[0], 1'b1);
    op_busy <= 1'b0;
    cmd(8'h50, 0, 0);
    cmd(8'h01, 64'hfc02, 2);
    cmd(8'h05, 0, 1);
    chk("volatile sr1", r[7:2], 6'h3f);
    cmd(8'hb7, 0, 0);
    host.hw_reset();
    cmd(8'h05, 0, 1);
    chk("sr1 reload", r[7:2], 6'h00);
    chk("qe reload", modes.quad_lane_enable_bit, 1'b1);
    chk("pin reset 3b", bank, 8'h00);
    $display("test status done");
    cmd(8'h38, 0, 0);
    chk("4-line on", modes.four_line_command_mode, 1'b1);
    q = 1'b1;
    cmd(8'h66, 0, 0);
    cmd(8'h99, 0, 0);
    chk("4-line reset", modes.four_line_command_mode, 1'b0);
    q = 1'b0;
    cmd(8'h38, 0, 0);
    q = 1'b1;
    cmd(8'hf5, 0, 0);
    q = 1'b0;
    chk("4-line off", modes.four_line_command_mode, 1'b0);
    qrd(1'b1, 8'ha5);
    chk("cont a5", modes.cont_read, 1'b1);
    chk("arr addr", arr_addr, 32'h1);
    qrd(1'b0, 8'h00);
    chk("cont 00", modes.cont_read, 1'b0);
    qrd(1'b1, 8'ha3);
    chk("cont ax", modes.cont_read, 1'b1);
    host.sel();
    repeat (4) host.byte_x(8'hff, 1'b1, r);
    host.desel();
    chk("cont forced exit", modes.cont_read, 1'b0);
    $display("test modes done");
    cmd(8'h5a, 64'h0000_3800_0000_0000, 8);
    chk("param dword", v, 32'hff5df622);
    chk("hold disable", v[23], 1'b0);
    chk("qe method", v[22:20], 3'b101);
    $display("test parameters done");
    tally_and_finish();
  end
endmodule
